// File: cpuex_alu8.sv
`timescale 1ns/1ps
`include "cpuex_regs.svh"

module cpuex_alu8 (
  // Operation and operands
  input  wire cpuex_pkg::cpuex_op_t op_code,
  input  wire logic [7:0]           dest_value,
  input  wire logic [7:0]           second_source_reg,
  input  wire logic [7:0]           immediate,
  input  wire logic                 carry_in,
  // Result
  output logic      [7:0]           result,
  output logic      [5:0]           flags,
  output logic      [5:0]           flag_mask
);
  import cpuex_pkg::*;

  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic       is_sub;
  logic       is_arith;
  logic       force_carry;
  logic [2:0] hcv;

  function automatic logic [2:0] add_hcv(input logic [7:0] x,
                                         input logic [7:0] y,
                                         input logic [7:0] r);
    add_hcv = {(x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]),
               (x[7] & y[7]) | (y[7] & ~r[7]) | (~r[7] & x[7]),
               (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7])};
  endfunction : add_hcv

  function automatic logic [2:0] sub_hcv(input logic [7:0] x,
                                         input logic [7:0] y,
                                         input logic [7:0] r);
    sub_hcv = {(~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]),
               (~x[7] & y[7]) | (y[7] & r[7]) | (r[7] & ~x[7]),
               (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7])};
  endfunction : sub_hcv

  always_comb begin
    a           = dest_value;
    b           = second_source_reg;
    cin         = 1'b0;
    is_sub      = 1'b0;
    is_arith    = 1'b1;
    force_carry = 1'b0;
    result      = `CPUEX_ZERO;
    flag_mask   = `CPUEX_MASK_ARITH;
    case (op_code)
      op_add: ;
      op_add_carry: cin = carry_in;
      op_sub: is_sub = 1'b1;
      op_sub_borrow_regs: begin
        is_sub = 1'b1;
        cin    = carry_in;
      end
      op_subtract_immediate: begin
        is_sub = 1'b1;
        b      = immediate;
      end
      op_sub_borrow_immediate: begin
        is_sub = 1'b1;
        b      = immediate;
        cin    = carry_in;
      end
      op_twos_complement: begin
        is_sub = 1'b1;
        a      = `CPUEX_ZERO;
        b      = dest_value;
      end
      op_plus_one: begin
        b         = 8'h01;
        flag_mask = `CPUEX_MASK_LOGIC;
      end
      op_minus_one: begin
        is_sub    = 1'b1;
        b         = 8'h01;
        flag_mask = `CPUEX_MASK_LOGIC;
      end
      default: begin
        is_arith  = 1'b0;
        flag_mask = `CPUEX_MASK_LOGIC;
        case (op_code)
          op_and:             result = a & b;
          op_and_immediate:   result = a & immediate;
          op_or:              result = a | b;
          op_or_immediate:    result = a | immediate;
          op_xor_regs:        result = a ^ b;
          op_set_bits_mask:   result = a | immediate;
          op_clear_bits_mask: result = a & (`CPUEX_ALL_ONES - immediate);
          op_zero_sign_test:  result = a & a;
          op_zero_register:   result = a ^ a;
          op_bitwise_invert: begin
            result      = `CPUEX_ALL_ONES - a;
            flag_mask   = `CPUEX_MASK_COMPL;
            force_carry = 1'b1;
          end
          op_all_ones_load: begin
            result    = `CPUEX_ALL_ONES;
            flag_mask = `CPUEX_MASK_NONE;
          end
          default:            result = `CPUEX_ZERO;
        endcase
      end
    endcase
    if (is_arith) begin
      result = is_sub ? a - b - {7'h00, cin} : a + b + {7'h00, cin};
    end
    hcv = is_sub ? sub_hcv(a, b, result) : add_hcv(a, b, result);
    flags[`CPUEX_FLAG_C] = force_carry | (is_arith & hcv[1]);
    flags[`CPUEX_FLAG_Z] = (result == `CPUEX_ZERO);
    flags[`CPUEX_FLAG_N] = result[7];
    flags[`CPUEX_FLAG_V] = is_arith & hcv[0];
    flags[`CPUEX_FLAG_S] = result[7] ^ (is_arith & hcv[0]);
    flags[`CPUEX_FLAG_H] = is_arith & hcv[2];
  end

endmodule : cpuex_alu8

// File: cpuex_core.sv
`timescale 1ns/1ps
`include "cpuex_regs.svh"

module cpuex_core (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  input  wire logic                 clock_enable,
  // Operation from the decoder
  input  wire logic                 op_valid,
  input  wire cpuex_pkg::cpuex_op_t op_code,
  input  wire logic [4:0]           dest_index,
  input  wire logic [7:0]           dest_value,
  input  wire logic [7:0]           second_source_reg,
  input  wire logic [7:0]           immediate,
  input  wire logic [15:0]          pair_value,
  input  wire logic [15:0]          z_pointer,
  input  wire logic [15:0]          program_counter,
  input  wire logic [11:0]          jump_offset,
  output logic                      op_ready,
  // Register file write back
  output logic                      result_write,
  output logic      [4:0]           result_index,
  output logic      [7:0]           result_value,
  output logic                      pair_write,
  output logic      [4:0]           pair_index,
  output logic      [15:0]          pair_result,
  // Program flow
  output logic                      pc_load,
  output logic      [15:0]          pc_target,
  output logic                      stack_push,
  output logic      [15:0]          stack_data,
  // Completion
  output logic                      op_done,
  output logic      [1:0]           op_cycles,
  output logic      [5:0]           status,
  // Register port
  input  wire logic [1:0]           reg_address,
  input  wire logic [7:0]           reg_write_data,
  input  wire logic                 reg_write_strobe,
  input  wire logic                 reg_read_strobe,
  output logic      [7:0]           reg_read_data
);
  import cpuex_pkg::*;

  cpuex_state_t state;
  cpuex_state_t next_state;
  logic         pend_pair;
  logic         pend_pc;
  logic         pend_call;
  logic [5:0]   pend_flags;
  logic [5:0]   pend_mask;
  logic         next_op_ready;
  logic         next_result_write;
  logic [4:0]   next_result_index;
  logic [7:0]   next_result_value;
  logic         next_pair_write;
  logic [4:0]   next_pair_index;
  logic [15:0]  next_pair_result;
  logic         next_pc_load;
  logic [15:0]  next_pc_target;
  logic         next_stack_push;
  logic [15:0]  next_stack_data;
  logic         next_op_done;
  logic [1:0]   next_op_cycles;
  logic [5:0]   next_status;
  logic [7:0]   next_reg_read_data;
  logic         next_pend_pair;
  logic         next_pend_pc;
  logic         next_pend_call;
  logic [5:0]   next_pend_flags;
  logic [5:0]   next_pend_mask;

  logic [7:0]   alu_result;
  logic [5:0]   alu_flags;
  logic [5:0]   alu_mask;
  logic [15:0]  mul_product;
  logic         mul_carry;
  logic         mul_zero;
  logic         word_sub;
  logic [15:0]  word_sum;
  logic [5:0]   word_flags;
  logic [15:0]  rel_target;

  // Only flags selected by the mask change
  function automatic logic [5:0] merge_flags(input logic [5:0] old,
                                             input logic [5:0] fresh,
                                             input logic [5:0] mask);
    merge_flags = (old & ~mask) | (fresh & mask);
  endfunction : merge_flags

  function automatic logic [1:0] cycles_of(input cpuex_op_t op);
    if (op == op_relative_call || op == op_indirect_call) begin
      cycles_of = `CPUEX_CYCLES_THREE;
    end else if (op >= op_word_add_immediate) begin
      cycles_of = `CPUEX_CYCLES_TWO;
    end else begin
      cycles_of = `CPUEX_CYCLES_ONE;
    end
  endfunction : cycles_of

  cpuex_alu8 u_alu8 (
    .op_code           (op_code),
    .dest_value        (dest_value),
    .second_source_reg (second_source_reg),
    .immediate         (immediate),
    .carry_in          (status[`CPUEX_FLAG_C]),
    .result            (alu_result),
    .flags             (alu_flags),
    .flag_mask         (alu_mask)
  );

  cpuex_mul u_mul (
    .multiplicand        (dest_value),
    .multiplier          (second_source_reg),
    .multiplicand_signed (!(op_code inside {op_unsigned_product,
                          op_fractional_unsigned_product})),
    .multiplier_signed   (op_code == op_signed_product ||
                          op_code == op_fractional_signed_product),
    .fractional          (op_code >= op_fractional_unsigned_product),
    .product             (mul_product),
    .carry               (mul_carry),
    .zero                (mul_zero)
  );

  // Word arithmetic on a pair; the constant is six bits wide
  always_comb begin
    word_sub = (op_code == op_word_subtract_immediate);
    word_sum = word_sub ? pair_value - {10'h000, immediate[5:0]}
                        : pair_value + {10'h000, immediate[5:0]};
    word_flags[`CPUEX_FLAG_N] = word_sum[15];
    word_flags[`CPUEX_FLAG_Z] = (word_sum == 16'h0000);
    word_flags[`CPUEX_FLAG_V] = word_sub ? pair_value[15] & ~word_sum[15]
                                         : ~pair_value[15] & word_sum[15];
    word_flags[`CPUEX_FLAG_C] = word_sub ? ~pair_value[15] & word_sum[15]
                                         : pair_value[15] & ~word_sum[15];
    word_flags[`CPUEX_FLAG_S] = word_sum[15] ^
                                word_flags[`CPUEX_FLAG_V];
    word_flags[`CPUEX_FLAG_H] = 1'b0;
    rel_target = program_counter + {{4{jump_offset[11]}}, jump_offset}
                 + `CPUEX_PC_STEP;
  end

  always_comb begin
    next_state         = state;
    next_result_write  = 1'b0;
    next_result_index  = result_index;
    next_result_value  = result_value;
    next_pair_write    = 1'b0;
    next_pair_index    = pair_index;
    next_pair_result   = pair_result;
    next_pc_load       = 1'b0;
    next_pc_target     = pc_target;
    next_stack_push    = 1'b0;
    next_stack_data    = stack_data;
    next_op_done       = 1'b0;
    next_op_cycles     = op_cycles;
    next_pend_pair     = pend_pair;
    next_pend_pc       = pend_pc;
    next_pend_call     = pend_call;
    next_pend_flags    = pend_flags;
    next_pend_mask     = pend_mask;
    next_status        = status;
    // A software write loses to a flag update in the same cycle
    if (reg_write_strobe && reg_address == `CPUEX_ADDR_STATUS) begin
      next_status = reg_write_data[5:0];
    end
    case (state)
      st_idle: begin
        if (op_valid) begin
          next_op_cycles = cycles_of(op_code);
          next_pend_pair = 1'b0;
          next_pend_pc   = 1'b0;
          next_pend_call = 1'b0;
          if (op_code < op_word_add_immediate) begin
            next_result_write = 1'b1;
            next_result_index = dest_index;
            next_result_value = alu_result;
            next_status = merge_flags(status, alu_flags,
                                      alu_mask);
            next_op_done      = 1'b1;
          end else if (op_code <= op_word_subtract_immediate) begin
            next_pair_index = dest_index;
            next_pair_result = word_sum;
            next_pend_pair  = 1'b1;
            next_pend_flags = word_flags;
            next_pend_mask  = `CPUEX_MASK_WORD;
            next_state      = st_second;
          end else if (op_code <= op_fractional_mixed_product) begin
            next_pair_index  = `CPUEX_PRODUCT_LOW;
            next_pair_result = mul_product;
            next_pend_pair   = 1'b1;
            next_pend_flags  = {4'h0, mul_zero, mul_carry};
            next_pend_mask   = `CPUEX_MASK_MUL;
            next_state       = st_second;
          end else begin
            next_pc_target = (op_code == op_indirect_jump ||
                              op_code == op_indirect_call)
                             ? z_pointer : rel_target;
            next_stack_data = program_counter + `CPUEX_PC_STEP;
            next_pend_pc    = 1'b1;
            next_pend_call  = (op_code == op_relative_call ||
                               op_code == op_indirect_call);
            next_pend_mask  = `CPUEX_MASK_NONE;
            next_state      = st_second;
          end
        end
      end
      st_second: begin
        if (pend_call) begin
          // Return address goes out one cycle ahead of the new target
          next_stack_push = 1'b1;
          next_state      = st_third;
        end else begin
          next_pair_write = pend_pair;
          next_pc_load    = pend_pc;
          next_status = merge_flags(status, pend_flags, pend_mask);
          next_op_done    = 1'b1;
          next_state      = st_idle;
        end
      end
      st_third: begin
        next_pc_load = 1'b1;
        next_op_done = 1'b1;
        next_state   = st_idle;
      end
      default: next_state = st_idle;
    endcase
    next_op_ready = (next_state == st_idle);
    next_reg_read_data = `CPUEX_ZERO;
    if (reg_read_strobe) begin
      if (reg_address == `CPUEX_ADDR_STATUS) begin
        next_reg_read_data = {2'b00, status};
      end else if (reg_address == `CPUEX_ADDR_CYCLES) begin
        next_reg_read_data = {6'h00, op_cycles};
      end else begin
        next_reg_read_data = `CPUEX_ZERO;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state         <= st_idle;
      op_ready      <= 1'b1;
      result_write  <= 1'b0;
      result_index  <= 5'h00;
      result_value  <= `CPUEX_ZERO;
      pair_write    <= 1'b0;
      pair_index    <= 5'h00;
      pair_result   <= 16'h0000;
      pc_load       <= 1'b0;
      pc_target     <= 16'h0000;
      stack_push    <= 1'b0;
      stack_data    <= 16'h0000;
      op_done       <= 1'b0;
      op_cycles     <= `CPUEX_CYCLES_RESET;
      status        <= `CPUEX_STATUS_RESET;
      reg_read_data <= `CPUEX_ZERO;
      pend_pair     <= 1'b0;
      pend_pc       <= 1'b0;
      pend_call     <= 1'b0;
      pend_flags    <= 6'h00;
      pend_mask     <= `CPUEX_MASK_NONE;
    end else if (clock_enable) begin
      state         <= next_state;
      op_ready      <= next_op_ready;
      result_write  <= next_result_write;
      result_index  <= next_result_index;
      result_value  <= next_result_value;
      pair_write    <= next_pair_write;
      pair_index    <= next_pair_index;
      pair_result   <= next_pair_result;
      pc_load       <= next_pc_load;
      pc_target     <= next_pc_target;
      stack_push    <= next_stack_push;
      stack_data    <= next_stack_data;
      op_done       <= next_op_done;
      op_cycles     <= next_op_cycles;
      status        <= next_status;
      reg_read_data <= next_reg_read_data;
      pend_pair     <= next_pend_pair;
      pend_pc       <= next_pend_pc;
      pend_call     <= next_pend_call;
      pend_flags    <= next_pend_flags;
      pend_mask     <= next_pend_mask;
    end
  end

endmodule : cpuex_core

// File: cpuex_core_assertions.sv
`timescale 1ns/1ps
module cpuex_core_assertions
  import cpuex_pkg::*;
(
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 reset,
  // Decoder side
  input wire logic                 clock_enable,
  input wire logic                 op_valid,
  input wire cpuex_pkg::cpuex_op_t op_code,
  input wire logic [7:0]           dest_value,
  // Results
  input wire logic                 op_ready,
  input wire logic                 result_write,
  input wire logic [7:0]           result_value,
  input wire logic                 pair_write,
  input wire logic [4:0]           pair_index,
  input wire logic                 pc_load,
  input wire logic                 stack_push,
  input wire logic                 op_done,
  input wire logic [5:0]           status
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic take;
  assign take = clock_enable && op_ready && op_valid;
  a_one_cycle: assert property (take && op_code < op_word_add_immediate
    |=> op_done && result_write) else $error("single op late");
  a_word_pair: assert property (take && op_code inside
    {op_word_add_immediate, op_word_subtract_immediate}
    |=> !op_ready && !pair_write ##1 pair_write && op_done)
    else $error("word op timing");
  a_product_pair: assert property (take && op_code inside
    {[op_unsigned_product:op_fractional_mixed_product]}
    |=> !op_done ##1 pair_write && op_done && pair_index == 5'h00)
    else $error("product timing");
  a_jump_two: assert property (take && op_code inside
    {op_relative_jump, op_indirect_jump} |=> !pc_load ##1 pc_load
    && op_done && status == $past(status, 2)) else $error("jump timing");
  a_call_three: assert property (take && op_code >= op_relative_call
    |=> !stack_push ##1 stack_push && !pc_load ##1 pc_load && op_done
    && status == $past(status, 3)) else $error("call timing");
  a_sign_xor: assert property (pair_write && pair_index != 5'h00
    |-> status[4] == (status[2] ^ status[3])) else $error("sign flag");
  a_ones_keep: assert property (take && op_code == op_all_ones_load
    |=> result_value == 8'hff && status == $past(status))
    else $error("all ones load");
  a_invert_carry: assert property (take && op_code == op_bitwise_invert
    |=> result_value == ~$past(dest_value) && status[0])
    else $error("invert result");
endmodule : cpuex_core_assertions

bind cpuex_core cpuex_core_assertions chk_u (.*);

// File: cpuex_core_tb.sv
`timescale 1ns/1ps
module cpuex_core_tb;
  import cpuex_pkg::*;
  logic clock = 1'b0;
  logic reset;
  logic op_valid = 1'b0, ws = 1'b0, rs = 1'b0, rd_pend = 1'b0;
  cpuex_op_t op_code = op_add;
  logic [4:0] di = 5'h00, pi, ri;
  logic [7:0] d = 8'h00, r = 8'h00, k = 8'h00, wd = 8'h00, rv, rdat;
  logic [15:0] pv, z = 16'h0000, pc = 16'h0000, pr, pct, sd;
  logic [11:0] off = 12'h000;
  logic [1:0] ra = 2'h0;
  logic [5:0] status, es = 6'h00;
  logic op_ready, rw, pw, pcl, sp, op_done;
  logic [31:0] seed = 32'h00000057;
  logic [21:0] q_res[$], q_pair[$], q_pc[$], q_push[$], q_rd[$];
  int n_mismatch = 0, check_count = 0;
  cpuex_core dut_u (.clock(clock), .reset(reset), .clock_enable(1'b1),
    .op_valid(op_valid), .op_code(op_code), .dest_index(di),
    .dest_value(d), .second_source_reg(r), .immediate(k), .pair_value(pv),
    .z_pointer(z), .program_counter(pc), .jump_offset(off),
    .op_ready(op_ready), .result_write(rw), .result_index(ri),
    .result_value(rv), .pair_write(pw), .pair_index(pi), .pair_result(pr),
    .pc_load(pcl), .pc_target(pct), .stack_push(sp), .stack_data(sd),
    .op_done(op_done), .op_cycles(), .status(status), .reg_address(ra),
    .reg_write_data(wd), .reg_write_strobe(ws), .reg_read_strobe(rs),
    .reg_read_data(rdat));
  cpuex_rf_model rf_u (.clock(clock), .reset(reset), .result_write(rw),
    .result_index(ri), .result_value(rv), .pair_write(pw), .pair_index(pi),
    .pair_result(pr), .dest_index(di), .pair_value(pv));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [21:0] ref8(input cpuex_op_t o,
      input logic [7:0] a, input logic [7:0] x, input logic [5:0] s);
    logic [8:0] w;
    logic [4:0] h;
    logic [7:0] y;
    logic ci, sub, v;
    logic [5:0] m;
    ci = (o inside {op_add_carry, op_sub_borrow_regs,
      op_sub_borrow_immediate}) & s[0];
    if (o == op_twos_complement) begin
      x = a;
      a = 8'h00;
    end
    sub = o inside {[op_sub:op_sub_borrow_immediate], op_twos_complement};
    w = sub ? {1'b0, a} - x - ci : {1'b0, a} + x + ci;
    h = sub ? {1'b0, a[3:0]} - x[3:0] - ci : {1'b0, a[3:0]} + x[3:0] + ci;
    v = ((a[7] ^ x[7]) == sub) && (w[7] != a[7]);
    y = w[7:0];
    m = (sub || o <= op_add_carry) ? 6'h2f : 6'h0e;
    case (o)
      op_and, op_and_immediate: y = a & x;
      op_or, op_or_immediate, op_set_bits_mask: y = a | x;
      op_xor_regs: y = a ^ x;
      op_clear_bits_mask: y = a & (8'hff - x);
      op_bitwise_invert: y = 8'hff - a;
      op_plus_one: y = a + 8'h01;
      op_minus_one: y = a - 8'h01;
      op_zero_sign_test: y = a & a;
      op_zero_register: y = a ^ a;
      op_all_ones_load: y = 8'hff;
      default: ;
    endcase
    if (m == 6'h0e)
      v = (o == op_plus_one) ? y == 8'h80 : o == op_minus_one && y == 8'h7f;
    if (o == op_bitwise_invert) m = 6'h0f;
    if (o == op_all_ones_load) m = 6'h00;
    w[8] = w[8] | (o == op_bitwise_invert);
    return {(s & ~m) | ({h[4], 1'b0, v, y[7], y == 8'h00, w[8]} & m),
      8'h00, y};
  endfunction : ref8
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : compare
  // Expected values use operands at the taking edge
  task automatic issue(input cpuex_op_t o, input logic [4:0] i);
    logic [21:0] t;
    logic [17:0] p;
    logic [15:0] q;
    logic sa, sb;
    seed = xs(seed);
    op_valid <= 1'b1;
    op_code <= o;
    di <= i;
    {z, d, r} <= seed;
    k <= seed[31:24] ^ seed[7:0];
    pc <= seed[23:8];
    off <= seed[11:0] ^ seed[31:20];
    do @(posedge clock); while (op_ready !== 1'b1);
    if (o < op_word_add_immediate) begin
      t = ref8(o, d, o inside {op_subtract_immediate, op_sub_borrow_immediate,
        op_and_immediate, op_or_immediate, op_set_bits_mask,
        op_clear_bits_mask} ? k : r, es);
      t[12:8] = i;
      q_res.push_back(t);
    end else if (o < op_unsigned_product) begin
      sa = o == op_word_subtract_immediate;
      t[16:0] = sa ? {1'b0, pv} - k[5:0] : {1'b0, pv} + k[5:0];
      sb = sa ? pv[15] & ~t[15] : ~pv[15] & t[15];
      t[21:17] = {es[5], t[15] ^ sb, sb, t[15], t[15:0] == 16'h0000};
      q_pair.push_back(t);
    end else if (o < op_relative_jump) begin
      sa = !(o inside {op_unsigned_product, op_fractional_unsigned_product});
      sb = o inside {op_signed_product, op_fractional_signed_product};
      p = $signed({sa & d[7], d}) * $signed({sb & r[7], r});
      q = o >= op_fractional_unsigned_product ? {p[14:0], 1'b0} : p[15:0];
      t = {es[5:2], q == 16'h0000, p[15], q};
      q_pair.push_back(t);
    end else begin
      q_pc.push_back(o inside {op_relative_jump, op_relative_call} ?
        pc + {{4{off[11]}}, off} + 16'h0001 : z);
      if (o >= op_relative_call) q_push.push_back(pc + 16'h0001);
      t = {es, 16'h0000};
    end
    es = t[21:16];
  endtask : issue
  task automatic idle;
    op_valid <= 1'b0;
    @(posedge clock);
  endtask : idle
  task automatic bus(input logic w, input logic rr, input logic [1:0] a,
      input logic [7:0] v);
    ws <= w;
    rs <= rr;
    ra <= a;
    wd <= v;
    @(posedge clock);
    if (rr) q_rd.push_back(v);
    if (w && a == 2'h0) es = v[5:0];
  endtask : bus
  task automatic end_of_test;
    if (n_mismatch == 0 && check_count > 0 && q_res.size() + q_pair.size()
        + q_pc.size() + q_push.size() + q_rd.size() == 0)
      $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  always @(posedge clock) begin
    if (rw === 1'b1)
      compare({status, 3'h0, ri, rv}, q_res.pop_front());
    if (pw === 1'b1)
      compare({status, pr}, q_pair.pop_front());
    if (pcl === 1'b1) compare(pct, q_pc.pop_front());
    if (sp === 1'b1) compare(sd, q_push.pop_front());
    if (rd_pend) compare(rdat, q_rd.pop_front());
    rd_pend <= rs;
  end
  initial forever #4 clock = ~clock;
  initial begin
    #20000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    reset = 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 80; i++)
      issue(cpuex_op_t'(i % 20), 5'(i));
    idle;
    // Gap lets the pair write land first
    for (int i = 0; i < 6; i++) begin
      issue(cpuex_op_t'(20 + i % 2), 5'h18);
      idle;
      repeat (3) @(posedge clock);
    end
    for (int i = 22; i < 32; i++) issue(cpuex_op_t'(i), 5'(i));
    idle;
    repeat (4) @(posedge clock);
    bus(1'b0, 1'b1, 2'h0, {2'b00, es});
    bus(1'b1, 1'b0, 2'h0, 8'h2b);
    bus(1'b1, 1'b0, 2'h1, 8'h55);
    bus(1'b0, 1'b1, 2'h0, 8'h2b);
    bus(1'b0, 1'b1, 2'h1, 8'h03);
    bus(1'b0, 1'b1, 2'h3, 8'h00);
    bus(1'b0, 1'b0, 2'h0, 8'h00);
    issue(op_sub_borrow_regs, 5'h03);
    idle;
    repeat (4) @(posedge clock);
    end_of_test;
  end
endmodule : cpuex_core_tb

// File: cpuex_mul.sv
`timescale 1ns/1ps
`include "cpuex_regs.svh"

module cpuex_mul (
  // Operands
  input  wire logic [7:0]  multiplicand,
  input  wire logic [7:0]  multiplier,
  input  wire logic        multiplicand_signed,
  input  wire logic        multiplier_signed,
  input  wire logic        fractional,
  // Result
  output logic      [15:0] product,
  output logic             carry,
  output logic             zero
);
  logic signed [8:0]  ext_a;
  logic signed [8:0]  ext_b;
  logic signed [17:0] full;
  logic        [15:0] raw;

  always_comb begin
    // Sign extension to nine bits covers all three operand mixes
    ext_a   = $signed({multiplicand_signed & multiplicand[7], multiplicand});
    ext_b   = $signed({multiplier_signed & multiplier[7], multiplier});
    full    = ext_a * ext_b;
    raw     = full[15:0];
    // Carry is the top product bit before the fractional shift
    carry   = raw[15];
    product = fractional ? {raw[14:0], 1'b0} : raw;
    zero    = (product == 16'h0000);
  end

endmodule : cpuex_mul

// File: cpuex_pkg.sv
package cpuex_pkg;

  typedef enum logic [4:0] {
    op_add                      = 5'h00,
    op_add_carry                = 5'h01,
    op_sub                      = 5'h02,
    op_sub_borrow_regs          = 5'h03,
    op_subtract_immediate       = 5'h04,
    op_sub_borrow_immediate     = 5'h05,
    op_and                      = 5'h06,
    op_and_immediate            = 5'h07,
    op_or                       = 5'h08,
    op_or_immediate             = 5'h09,
    op_xor_regs                 = 5'h0a,
    op_set_bits_mask            = 5'h0b,
    op_clear_bits_mask          = 5'h0c,
    op_bitwise_invert           = 5'h0d,
    op_twos_complement          = 5'h0e,
    op_plus_one                 = 5'h0f,
    op_minus_one                = 5'h10,
    op_zero_sign_test           = 5'h11,
    op_zero_register            = 5'h12,
    op_all_ones_load            = 5'h13,
    op_word_add_immediate       = 5'h14,
    op_word_subtract_immediate  = 5'h15,
    op_unsigned_product         = 5'h16,
    op_signed_product           = 5'h17,
    op_mixed_sign_product       = 5'h18,
    op_fractional_unsigned_product = 5'h19,
    op_fractional_signed_product   = 5'h1a,
    op_fractional_mixed_product    = 5'h1b,
    op_relative_jump            = 5'h1c,
    op_indirect_jump            = 5'h1d,
    op_relative_call            = 5'h1e,
    op_indirect_call            = 5'h1f
  } cpuex_op_t;

  typedef enum logic [2:0] {
    st_idle   = 3'b001,
    st_second = 3'b010,
    st_third  = 3'b100
  } cpuex_state_t;

endpackage : cpuex_pkg

// File: cpuex_regs.svh
`ifndef CPUEX_REGS_SVH
`define CPUEX_REGS_SVH

// Status flag bit positions
`define CPUEX_FLAG_C 0
`define CPUEX_FLAG_Z 1
`define CPUEX_FLAG_N 2
`define CPUEX_FLAG_V 3
`define CPUEX_FLAG_S 4
`define CPUEX_FLAG_H 5

// Flag update masks
`define CPUEX_MASK_NONE  6'h00
`define CPUEX_MASK_ARITH 6'h2f
`define CPUEX_MASK_LOGIC 6'h0e
`define CPUEX_MASK_COMPL 6'h0f
`define CPUEX_MASK_WORD  6'h1f
`define CPUEX_MASK_MUL   6'h03

// Register port offsets
`define CPUEX_ADDR_STATUS 2'h0
`define CPUEX_ADDR_CYCLES 2'h1

// Reset values
`define CPUEX_STATUS_RESET 6'h00
`define CPUEX_CYCLES_RESET 2'h0

// Execution cycle counts
`define CPUEX_CYCLES_ONE   2'h1
`define CPUEX_CYCLES_TWO   2'h2
`define CPUEX_CYCLES_THREE 2'h3

// Constants of the datapath
`define CPUEX_ALL_ONES     8'hff
`define CPUEX_ZERO         8'h00
`define CPUEX_PRODUCT_LOW  5'h00
`define CPUEX_PC_STEP      16'h0001

`endif

// File: cpuex_rf_model.sv
`timescale 1ns/1ps
module cpuex_rf_model (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // Write back
  input wire logic        result_write,
  input wire logic [4:0]  result_index,
  input wire logic [7:0]  result_value,
  input wire logic        pair_write,
  input wire logic [4:0]  pair_index,
  input wire logic [15:0] pair_result,
  // Pair read
  input wire logic [4:0]  dest_index,
  output logic     [15:0] pair_value
);
  logic [7:0] regs [32];
  assign pair_value = {regs[dest_index + 5'h01], regs[dest_index]};
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) regs[i] <= 8'h00;
    end else begin
      if (result_write) regs[result_index] <= result_value;
      if (pair_write) begin
        regs[pair_index] <= pair_result[7:0];
        regs[pair_index + 5'h01] <= pair_result[15:8];
      end
    end
  end
endmodule : cpuex_rf_model
